// ===== hdl/rscd_pkg.sv
package rscd_pkg;

	// Strap vector layout
	localparam int STRAP_W          = 8;
	localparam int STRAP_OPMODE_LO  = 0;
	localparam int STRAP_OPMODE_HI  = 1;
	localparam int STRAP_BYTE_ORDER = 2;
	localparam int STRAP_HOST_WIDTH = 3;
	localparam int STRAP_PCI_SELECT = 4;
	localparam int STRAP_AUTOINIT   = 5;
	localparam int STRAP_BOOT_LO    = 6;
	localparam int STRAP_BOOT_HI    = 7;

	// Levels the internal pulls give with nothing fitted on the board
	localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h8F;

	// Strap codes
	localparam logic [1:0] OPMODE_BSCAN    = 2'h0;
	localparam logic [1:0] OPMODE_EMU      = 2'h3;
	localparam logic [1:0] BOOT_CODE_NONE  = 2'h0;
	localparam logic [1:0] BOOT_CODE_HOST  = 2'h1;
	localparam logic [1:0] BOOT_CODE_RSVD  = 2'h2;
	localparam logic [1:0] BOOT_CODE_ROM8  = 2'h3;
	localparam logic       BYTE_ORDER_BIG  = 1'h0;
	localparam logic       HOST_WIDTH_WIDE = 1'h1;
	localparam logic       PCI_SELECTED    = 1'h1;
	localparam logic       AUTOINIT_ON     = 1'h1;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

	// Host data lines
	localparam int HOST_DATA_W      = 32;
	localparam int HOST_DATA_HALF_W = 16;

	// Register bus
	localparam int                ADDR_W       = 8;
	localparam int                DATA_W       = 32;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h04;
	localparam int                CTRL_ACK_BIT = 0;

	// Status fields
	localparam int STAT_OPMODE_LO  = 0;
	localparam int STAT_LITTLE     = 2;
	localparam int STAT_WIDE       = 3;
	localparam int STAT_PCI        = 4;
	localparam int STAT_AUTOINIT   = 5;
	localparam int STAT_BOOT_LO    = 6;
	localparam int STAT_CFG_ERROR  = 8;
	localparam int STAT_PENDING    = 9;
	localparam int STAT_USED_W     = 10;

	typedef enum logic [1:0] {
		RSCD_OPM_BSCAN_NORMAL,
		RSCD_OPM_EMU_NORMAL,
		RSCD_OPM_RESERVED
	} rscd_opmode_e;

	typedef enum logic [1:0] {
		RSCD_BOOT_NONE,
		RSCD_BOOT_HOST,
		RSCD_BOOT_RESERVED,
		RSCD_BOOT_ROM8
	} rscd_boot_e;

endpackage

// ===== hdl/rscd_strap_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rscd_strap_if;
	import rscd_pkg::*;

	logic [STRAP_W-1:0] rawStraps;
	logic [STRAP_W-1:0] filtStraps;

	modport sync (
		input  rawStraps,
		output filtStraps
	);

	modport core (
		output rawStraps,
		input  filtStraps
	);

endinterface

`default_nettype wire

// ===== hdl/rscd_strap_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rscd_strap_sync
	import rscd_pkg::*;
(
	input  wire logic clk,
	rscd_strap_if.sync strapBus
);

	typedef struct packed {
		logic [STRAP_W-1:0] stage1;
		logic [STRAP_W-1:0] stage2;
		logic [STRAP_W-1:0] stage3;
		logic [STRAP_W-1:0] filt;
	} rscd_sync_s;

	rscd_sync_s         state_reg;
	rscd_sync_s         state_next;
	logic [STRAP_W-1:0] filtNext;

	// A level counts only once stages two and three agree
	for (genvar i = 0; i < STRAP_W; i++) begin : g_bit
		assign filtNext[i] = (state_reg.stage2[i] == state_reg.stage3[i]) ?
			state_reg.stage3[i] : state_reg.filt[i];
	end

	// No reset here: the pipeline must keep sampling pins while reset is held
	always_comb begin
		state_next        = state_reg;
		state_next.stage1 = strapBus.rawStraps;
		state_next.stage2 = state_reg.stage1;
		state_next.stage3 = state_reg.stage2;
		state_next.filt   = filtNext;
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	assign strapBus.filtStraps = state_reg.filt;

endmodule // rscd_strap_sync

`default_nettype wire

// ===== hdl/rscd_strap_decoder.sv
// Summary of operation
// [R1] Decode mode strap: 00 scan, 11 emulation.
// [R2] Both valid modes let the core run freely.
// [R3] Board leaves test reset pulled low.
// [R4] Byte order strap: 0 big, 1 little.
// [R5] Narrow host port: upper lines stay released.
// [R6] Wide host port drives all data lines.
// [R7] Host width taken from strap at reset.
// [R8] Select host port plus GPIO, or PCI.
// [R9] Autoinit from EEPROM only when strap 1.
// [R10] Board keeps autoinit low without PCI.
// [R11] Board straps a valid boot mode.
// [R12] Boot: none, host, reserved, 8-bit ROM.
// [R13] Sample in reset, latch at release, hold.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rscd_strap_decoder
	import rscd_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic [1:0]             operatingModeStrap,
	input  wire logic                   byteOrderStrap,
	input  wire logic                   hostWidthStrap,
	input  wire logic                   pciSelectStrap,
	input  wire logic                   eepromAutoinitStrap,
	input  wire logic                   bootSourceStrapHigh,
	input  wire logic                   bootSourceStrapLow,
	input  wire logic                   hostPortDrive,
	input  wire logic [ADDR_W-1:0]      regAddr,
	input  wire logic [DATA_W-1:0]      regWrData,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	output logic      [DATA_W-1:0]      regRdData,
	output var rscd_opmode_e            operatingMode,
	output logic                        freeRunning,
	output logic                        littleEndian,
	output logic                        hostPortWide,
	output logic      [HOST_DATA_W-1:0] hostDataOe_n,
	output logic                        hostPortEnable,
	output logic                        upperGeneralIoEnable,
	output logic                        pciEnable,
	output logic                        eepromAutoinitEnable,
	output logic                        eepromAutoinitStart,
	output var rscd_boot_e              bootSource,
	output logic                        configError
);

	typedef struct packed {
		logic [STRAP_W-1:0]     straps;
		logic                   srstSeen;
		logic                   autoinitStart;
		logic                   autoinitPending;
		logic [HOST_DATA_W-1:0] hostOe_n;
		logic [DATA_W-1:0]      rdData;
	} rscd_state_s;

	rscd_state_s state_reg;
	rscd_state_s state_next;

	rscd_strap_if strapBus ();

	logic [1:0]              opCode;
	logic [1:0]              bootCode;
	logic                    wideDecoded;
	logic                    pciDecoded;
	logic                    autoinitDecoded;
	logic                    opReserved;
	logic                    bootReserved;
	logic                    autoinitConflict;
	logic                    released;
	logic                    ackWrite;
	logic [HOST_DATA_W-1:0]  driveMask;
	logic [STAT_USED_W-1:0]  statusWord;
	rscd_opmode_e            opDecoded;
	rscd_boot_e              bootDecoded;

	assign strapBus.rawStraps = {bootSourceStrapHigh, bootSourceStrapLow,
		eepromAutoinitStrap, pciSelectStrap, hostWidthStrap, byteOrderStrap,
		operatingModeStrap};

	rscd_strap_sync u_sync (
		.clk      (clk),
		.strapBus (strapBus.sync)
	);

	assign opCode   = state_reg.straps[STRAP_OPMODE_HI:STRAP_OPMODE_LO];
	assign bootCode = state_reg.straps[STRAP_BOOT_HI:STRAP_BOOT_LO];

	// Operating mode
	always_comb begin
		case (opCode)
			OPMODE_BSCAN: opDecoded = RSCD_OPM_BSCAN_NORMAL;	// [R1]
			OPMODE_EMU:   opDecoded = RSCD_OPM_EMU_NORMAL;	// [R1]
			default:      opDecoded = RSCD_OPM_RESERVED;
		endcase
	end

	assign opReserved = (opDecoded == RSCD_OPM_RESERVED);

	// Boot source
	always_comb begin
		case (bootCode)
			BOOT_CODE_NONE: bootDecoded = RSCD_BOOT_NONE;	// [R12]
			BOOT_CODE_HOST: bootDecoded = RSCD_BOOT_HOST;	// [R12]
			BOOT_CODE_ROM8: bootDecoded = RSCD_BOOT_ROM8;	// [R12]
			default:        bootDecoded = RSCD_BOOT_RESERVED;
		endcase
	end

	assign bootReserved = (bootDecoded == RSCD_BOOT_RESERVED);

	assign wideDecoded = (state_reg.straps[STRAP_HOST_WIDTH] == HOST_WIDTH_WIDE);	// [R7]
	assign pciDecoded  = (state_reg.straps[STRAP_PCI_SELECT] == PCI_SELECTED);	// [R8]

	// A pulled-up autoinit strap without PCI is a board fault; never act on it
	assign autoinitConflict = (state_reg.straps[STRAP_AUTOINIT] == AUTOINIT_ON) && !pciDecoded;
	assign autoinitDecoded  = (state_reg.straps[STRAP_AUTOINIT] == AUTOINIT_ON) && pciDecoded;	// [R9]

	// First cycle out of reset
	assign released = state_reg.srstSeen && !srst;
	assign ackWrite = regWrite && (regAddr == REG_CTRL) && regWrData[CTRL_ACK_BIT];

	// Lower half follows the host port, upper half only when wide
	assign driveMask = {{HOST_DATA_HALF_W{hostPortDrive && pciDecoded == 1'b0 && wideDecoded}},	// [R5] [R6]
		{HOST_DATA_HALF_W{hostPortDrive && pciDecoded == 1'b0}}};

	assign statusWord = {state_reg.autoinitPending,
		opReserved || bootReserved || autoinitConflict,
		bootCode, autoinitDecoded, pciDecoded, wideDecoded,
		state_reg.straps[STRAP_BYTE_ORDER], opCode};

	always_comb begin
		state_next          = state_reg;
		state_next.srstSeen = srst;
		state_next.hostOe_n = ~driveMask;
		state_next.rdData   = '0;
		if (regRead && (regAddr == REG_STATUS)) begin
			state_next.rdData = {{(DATA_W-STAT_USED_W){1'b0}}, statusWord};
		end
		// Start pulse goes out once, in the cycle after release
		state_next.autoinitStart = released && autoinitDecoded;	// [R9]
		if (released && autoinitDecoded) begin
			state_next.autoinitPending = 1'b1;
		end else if (ackWrite) begin
			state_next.autoinitPending = 1'b0;
		end
		if (srst) begin
			// Straps follow the pins while reset is held, then freeze
			state_next.straps          = strapBus.filtStraps;	// [R13]
			state_next.autoinitStart   = 1'b0;
			state_next.autoinitPending = 1'b0;
			state_next.hostOe_n        = '1;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	assign regRdData            = state_reg.rdData;
	assign operatingMode        = opDecoded;
	assign freeRunning          = !opReserved;	// [R2]
	assign littleEndian         = (state_reg.straps[STRAP_BYTE_ORDER] != BYTE_ORDER_BIG);	// [R4]
	assign hostPortWide         = wideDecoded;
	assign hostDataOe_n         = state_reg.hostOe_n;
	assign hostPortEnable       = !pciDecoded;	// [R8]
	assign upperGeneralIoEnable = !pciDecoded;	// [R8]
	assign pciEnable            = pciDecoded;
	assign eepromAutoinitEnable = autoinitDecoded;
	assign eepromAutoinitStart  = state_reg.autoinitStart;
	assign bootSource           = bootDecoded;
	assign configError          = opReserved || bootReserved || autoinitConflict;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_STRAPS_HELD: assert property (!$past(srst) |-> $stable(state_reg.straps))	// [R13]
		else $error("Straps changed outside reset");

	AST_WIDTH_AT_RESET: assert property ($fell(srst) |-> hostPortWide == $past(strapBus.filtStraps[STRAP_HOST_WIDTH]))	// [R7]
		else $error("Host width not taken from strap at release");

	AST_OPMODE: assert property ((operatingMode == RSCD_OPM_EMU_NORMAL) == (opCode == OPMODE_EMU)
		&& (operatingMode == RSCD_OPM_BSCAN_NORMAL) == (opCode == OPMODE_BSCAN))	// [R1]
		else $error("Operating mode decode wrong");

	AST_FREE_RUN: assert property (freeRunning == (opCode == OPMODE_BSCAN || opCode == OPMODE_EMU))	// [R2]
		else $error("Free running flag wrong");

	AST_ENDIAN: assert property ($fell(srst) |-> littleEndian == $past(strapBus.filtStraps[STRAP_BYTE_ORDER]))	// [R4]
		else $error("Byte order not taken from strap");

	AST_NARROW_RELEASE: assert property (!hostPortWide |=> &hostDataOe_n[HOST_DATA_W-1:HOST_DATA_HALF_W])	// [R5]
		else $error("Upper host lines driven in narrow mode");

	AST_WIDE_DRIVE: assert property (hostPortWide && hostPortEnable && hostPortDrive ##1 !srst
		|-> hostDataOe_n == '0)	// [R6]
		else $error("Wide host port not driving all lines");

	AST_PCI_SELECT: assert property (hostPortEnable == !pciEnable && upperGeneralIoEnable == hostPortEnable)	// [R8]
		else $error("Host port and PCI selection inconsistent");

	AST_AUTOINIT_START: assert property ($fell(srst) |=> eepromAutoinitStart == eepromAutoinitEnable
		##1 !eepromAutoinitStart)	// [R9]
		else $error("Autoinit start pulse wrong");

	AST_AUTOINIT_GATE: assert property (eepromAutoinitStart |-> pciEnable
		&& state_reg.straps[STRAP_AUTOINIT] == AUTOINIT_ON)	// [R9]
		else $error("Autoinit started without strap or PCI");

	AST_BOOT_HOST: assert property ((bootSource == RSCD_BOOT_HOST) == (bootCode == BOOT_CODE_HOST)
		&& (bootSource == RSCD_BOOT_ROM8) == (bootCode == BOOT_CODE_ROM8))	// [R12]
		else $error("Boot source decode wrong");

	// Reserved codes must never look like a running mode
	AST_OPMODE_RSVD: assert property (opCode != OPMODE_BSCAN && opCode != OPMODE_EMU	// [R1]
		|-> operatingMode == RSCD_OPM_RESERVED && !freeRunning && configError)
		else $error("Reserved mode code not flagged");

	// Settings latched at release must not move until the next reset
	AST_OPMODE_HELD: assert property (!$past(srst) |-> $stable(operatingMode))	// [R1]
		else $error("Operating mode changed outside reset");

	AST_FREE_RUN_VALID: assert property (operatingMode != RSCD_OPM_RESERVED |-> freeRunning)	// [R2]
		else $error("Valid mode not free running");

	AST_ENDIAN_DECODE: assert property (littleEndian	// [R4]
		== (state_reg.straps[STRAP_BYTE_ORDER] != BYTE_ORDER_BIG))
		else $error("Byte order decode wrong");

	AST_ENDIAN_HELD: assert property (!$past(srst) |-> $stable(littleEndian))	// [R4]
		else $error("Byte order changed outside reset");

	// Narrow port still drives its lower half
	AST_NARROW_LOWER: assert property (!hostPortWide && hostPortEnable && hostPortDrive	// [R5]
		|=> hostDataOe_n[HOST_DATA_HALF_W-1:0] == '0)
		else $error("Lower host lines not driven in narrow mode");

	AST_IDLE_RELEASE: assert property (!hostPortDrive |=> &hostDataOe_n)	// [R5]
		else $error("Host lines driven without a request");

	AST_WIDE_DECODE: assert property (hostPortWide	// [R6]
		== (state_reg.straps[STRAP_HOST_WIDTH] == HOST_WIDTH_WIDE))
		else $error("Host width decode wrong");

	AST_WIDTH_HELD: assert property (!$past(srst) |-> $stable(hostPortWide))	// [R7]
		else $error("Host width changed outside reset");

	AST_HOST_SELECT: assert property (pciEnable == (state_reg.straps[STRAP_PCI_SELECT] == PCI_SELECTED))	// [R8]
		else $error("Peripheral selection decode wrong");

	AST_PCI_NO_DRIVE: assert property (pciEnable |=> &hostDataOe_n)	// [R8]
		else $error("Host lines driven while PCI selected");

	AST_PCI_HELD: assert property (!$past(srst) |-> $stable(pciEnable))	// [R8]
		else $error("Peripheral selection changed outside reset");

	// A strap conflict must be reported, never acted on
	AST_AUTOINIT_CONFLICT: assert property (state_reg.straps[STRAP_AUTOINIT] == AUTOINIT_ON && !pciEnable	// [R9]
		|-> !eepromAutoinitEnable && configError)
		else $error("Autoinit strap without PCI not flagged");

	AST_AUTOINIT_DECODE: assert property (eepromAutoinitEnable	// [R9]
		== (state_reg.straps[STRAP_AUTOINIT] == AUTOINIT_ON && pciEnable))
		else $error("Autoinit enable decode wrong");

	AST_AUTOINIT_ONCE: assert property (!$past(srst) && !$past(srst, 2) |-> !eepromAutoinitStart)	// [R9]
		else $error("Autoinit start outside release");

	AST_PENDING_SET: assert property ($fell(srst) |=> state_reg.autoinitPending == eepromAutoinitEnable)	// [R9]
		else $error("Autoinit pending not set at release");

	AST_PENDING_CLEAR: assert property (ackWrite && !released |=> !state_reg.autoinitPending)	// [R9]
		else $error("Autoinit pending not cleared by write");

	AST_BOOT_RSVD: assert property ((bootSource == RSCD_BOOT_NONE) == (bootCode == BOOT_CODE_NONE)	// [R12]
		&& (bootSource == RSCD_BOOT_RESERVED) == (bootCode == BOOT_CODE_RSVD))
		else $error("Boot none or reserved decode wrong");

	AST_BOOT_ERROR: assert property (bootSource == RSCD_BOOT_RESERVED |-> configError)	// [R12]
		else $error("Reserved boot code not flagged");

	AST_BOOT_HELD: assert property (!$past(srst) |-> $stable(bootSource))	// [R12]
		else $error("Boot source changed outside reset");

	// Read data stands for one cycle only
	AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdData == '0)	// [R13]
		else $error("Read data without a read");

	AST_STATUS_READ: assert property (regRead && regAddr == REG_STATUS	// [R13]
		|=> regRdData[STAT_OPMODE_LO+1:STAT_OPMODE_LO] == opCode
		&& regRdData[STAT_LITTLE] == littleEndian && regRdData[STAT_WIDE] == hostPortWide
		&& regRdData[STAT_PCI] == pciEnable && regRdData[STAT_AUTOINIT] == eepromAutoinitEnable
		&& regRdData[STAT_BOOT_LO+1:STAT_BOOT_LO] == bootCode && regRdData[STAT_CFG_ERROR] == configError)
		else $error("Status word does not match decoded straps");

	AST_STATUS_PENDING: assert property (regRead && regAddr == REG_STATUS	// [R9]
		|=> regRdData[STAT_PENDING] == $past(state_reg.autoinitPending))
		else $error("Status pending bit wrong");

endmodule // rscd_strap_decoder

`default_nettype wire

// ===== hdl/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== sim/rscd_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module rscd_strap_board
	import rscd_pkg::*;
(
	input  wire logic [STRAP_W-1:0] fitted,
	input  wire logic               allowBad,
	output logic      [STRAP_W-1:0] pins
);
	// Test reset keeps its pull-down; that pin lies outside this block
	always_comb begin
		pins = fitted;
		if (!allowBad && fitted[STRAP_PCI_SELECT] != PCI_SELECTED) begin
			pins[STRAP_AUTOINIT] = 1'b0;
		end
		if (!allowBad && fitted[STRAP_BOOT_HI:STRAP_BOOT_LO] == BOOT_CODE_RSVD) begin
			pins[STRAP_BOOT_HI:STRAP_BOOT_LO] = BOOT_CODE_ROM8;
		end
	end
endmodule // rscd_strap_board

`default_nettype wire

// ===== sim/reset_strap_config_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module reset_strap_config_decoder_tb_top;
	import rscd_pkg::*;
	logic clk = 0, srst = 1, drv = 0, regWrite = 0, regRead = 0, allowBad = 0, rdPend = 0, pndExp;
	logic [7:0] fitted = 0, pins, eff;
	logic [ADDR_W-1:0] regAddr = 0;
	logic [DATA_W-1:0] regWrData = 0, regRdData, hostDataOe_n;
	logic freeRunning, littleEndian, hostPortWide, hostPortEnable, upperGeneralIoEnable;
	logic pciEnable, eepromAutoinitEnable, eepromAutoinitStart, configError;
	rscd_opmode_e operatingMode, modeExp;
	rscd_boot_e bootSource;
	logic [63:0] expQ[$];
	logic [63:0] note;
	int errTotal = 0, checksDone = 0, cyc = 0, seed = 32'h3949_7ae9;
	logic [31:0] starts;
	logic errExp;

	initial forever #12.5 clk = ~clk;

	rscd_strap_board board_u (.fitted(fitted), .allowBad(allowBad), .pins(pins));

	rscd_strap_decoder dut_u (.clk(clk), .srst(srst), .operatingModeStrap(pins[1:0]),
		.byteOrderStrap(pins[2]), .hostWidthStrap(pins[3]), .pciSelectStrap(pins[4]),
		.eepromAutoinitStrap(pins[5]), .bootSourceStrapHigh(pins[7]), .bootSourceStrapLow(pins[6]),
		.hostPortDrive(drv), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .operatingMode(operatingMode),
		.freeRunning(freeRunning), .littleEndian(littleEndian), .hostPortWide(hostPortWide),
		.hostDataOe_n(hostDataOe_n), .hostPortEnable(hostPortEnable),
		.upperGeneralIoEnable(upperGeneralIoEnable), .pciEnable(pciEnable),
		.eepromAutoinitEnable(eepromAutoinitEnable), .eepromAutoinitStart(eepromAutoinitStart),
		.bootSource(bootSource), .configError(configError));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rdPend) begin
			note = expQ.pop_front();
			chk(regRdData & note[63:32], note[31:0], "read");
		end
		rdPend <= regRead;
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			errTotal++;
			wrap_up();
		end
	end

	// Strobes stay up between back-to-back requests; idle drops them
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		regWrite <= 0;
		regRead <= 1;
		regAddr <= a;
		expQ.push_back({m, e});
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regRead <= 0;
		regWrite <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
	endtask

	task automatic idle();
		regRead <= 0;
		regWrite <= 0;
	endtask

	function automatic logic [31:0] stat(input logic p);
		return {22'h0, p, errExp, eff[7:6], eff[5] & eff[4], eff[4:2], eff[1:0]};
	endfunction

	initial begin
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			srst <= 1;
			fitted <= 8'($random(seed));
			@(posedge clk);
			fitted[1:0] <= i[1:0];
			fitted[7:6] <= i[3:2];
			allowBad <= i[4];
			repeat (10) @(posedge clk);
			srst <= 0;
			#1;
			eff = pins;
			modeExp = eff[1:0] == OPMODE_BSCAN ? RSCD_OPM_BSCAN_NORMAL
				: eff[1:0] == OPMODE_EMU ? RSCD_OPM_EMU_NORMAL : RSCD_OPM_RESERVED;
			pndExp = eff[5] & eff[4];
			errExp = modeExp == RSCD_OPM_RESERVED || eff[7:6] == BOOT_CODE_RSVD || (eff[5] & ~eff[4]);
			starts = 0;
			repeat (4) begin
				@(posedge clk);
				#1;
				starts = starts + 32'(eepromAutoinitStart);
			end
			@(posedge clk);
			fitted <= ~fitted;
			repeat (5) @(posedge clk);
			#1;
			chk(operatingMode, modeExp, "mode");
			chk(freeRunning, modeExp != RSCD_OPM_RESERVED, "free");
			chk(littleEndian, eff[2], "endian");
			chk(hostPortWide, eff[3], "width");
			chk({pciEnable, hostPortEnable, upperGeneralIoEnable}, {eff[4], ~eff[4], ~eff[4]}, "pci");
			chk(eepromAutoinitEnable, pndExp, "autoinit");
			chk(starts, pndExp, "start");
			chk(bootSource, eff[7:6], "boot");
			chk(configError, errExp, "err");
			@(posedge clk);
			rd(REG_STATUS, 32'hFFFF_FFFF, stat(pndExp));
			wr(REG_CTRL, 32'h0000_0001);
			rd(REG_STATUS, 32'hFFFF_FFFF, stat(1'b0));
			rd(8'h4C, 32'hFFFF_FFFF, 32'h0000_0000);
			idle();
			drv <= 1;
			repeat (2) @(posedge clk);
			#1;
			chk(hostDataOe_n[15:0], eff[4] ? 16'hFFFF : 16'h0000, "lower");
			chk(hostDataOe_n[31:16], (eff[4] | ~eff[3]) ? 16'hFFFF : 16'h0000, "upper");
			@(posedge clk);
			drv <= 0;
			repeat (2) @(posedge clk);
			#1;
			chk(hostDataOe_n, 32'hFFFF_FFFF, "release");
		end
		wrap_up();
	end
endmodule // reset_strap_config_decoder_tb_top

`default_nettype wire
